// ---- sgc_params.svh ----
// Purpose: constants for the general configuration and mode select registers
// Assumes: 8-bit registers on the serial control bus register port
// Notes: offsets, bit positions, reset values and filter length
//
// Operation
// - General configuration bit 7 enables the back-channel CRC checker; reset leaves it enabled.
// - Bit 5 set: forwarded writes hitting the deserializer or with pass_all are acknowledged at once, not awaiting remote acknowledge.
// - While a port's auto acknowledge is active, remote not-acknowledge for that port never reaches the local master.
// - Bit 4 set (reset): DE, HS, VS pulses under two clocks are rejected.
// - Bit 3 set: transactions matching a slave alias go to the remote deserializer.
// - Auto-ack and pass-through are banked per port; port select chooses which port's copy is written and read.
// - Bit 1 set (reset): switch to internal oscillator when pixel clock absent.
// - Mode select bit 7 sets failsafe level: 0 high, 1 low; resets to 1.
// - Mode select bit 5 held at 1 keeps CRC error counters cleared.
// - Mode select bit 4 set keeps video from asserting during blanking.
////////////////////////////////////////////////////////////////////////////////
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// Register offsets
`define SGC_ADDR_GEN 8'h03
`define SGC_ADDR_MODE 8'h04

// Reset values
`define SGC_GEN_RESET 8'hd2
`define SGC_MODE_RESET 8'h80

// Reserved bits of each register, read back at their reset value
`define SGC_GEN_RSVD_MASK 8'h45
`define SGC_MODE_RSVD_MASK 8'h4f

// General configuration fields
`define SGC_GEN_CRC_EN 7
`define SGC_GEN_AUTO_ACK 5
`define SGC_GEN_FILTER_EN 4
`define SGC_GEN_PASS_THRU 3
`define SGC_GEN_CLK_AUTO 1

// Mode select fields
`define SGC_MODE_FAILSAFE 7
`define SGC_MODE_CRC_CLR 5
`define SGC_MODE_VIDEO_GATE 4

// Shortest accepted pulse on the sync inputs, in input clocks
`define SGC_FILTER_CYCLES 2

`endif

// ---- sgc_pkg.sv ----
// Purpose: shared types for the serializer configuration block
// Assumes: nothing beyond the params header
// Notes: structs carry the register port and I2C decision inputs
package sgc_pkg;

  // Register port request from the serial control bus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgc_reg_req_t;

  // One local I2C transaction as decoded by the bus slave
  typedef struct packed {
    logic valid;
    logic port;
    logic is_write;
    logic des_hit;
    logic alias_hit;
    logic pass_all;
  } sgc_i2c_req_t;

  // Answer coming back over the back channel for a forwarded write
  typedef struct packed {
    logic valid;
    logic port;
    logic nack;
  } sgc_remote_ans_t;

  // Sync inputs: bit 2 data enable, bit 1 horizontal, bit 0 vertical
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
  } sgc_sync_t;

endpackage

// ---- sgc_sync_filter.sv ----
// Purpose: two-clock glitch filter on the DE, HS and VS inputs
// Assumes: inputs synchronous to clock, which stands for the pixel clock
// Notes: adds one cycle of latency in bypass, two when filtering
`timescale 1ns/1ps
`include "sgc_params.svh"

module sgc_sync_filter (
  input wire logic clock,
  input wire logic rst,
  input wire logic filter_en,
  input wire sgc_pkg::sgc_sync_t sync_in,
  output sgc_pkg::sgc_sync_t sync_out
);

  logic [2:0] raw;
  logic [2:0] held;
  assign raw = sync_in;
  assign sync_out = held;

  ////////////////////////////////////////////////////////////////////////////
  // One filter per line
  for (genvar i = 0; i < 3; i++)
  begin : g_line
    logic [1:0] run;
    logic next_run_hit;
    assign next_run_hit = (run + 2'd1) >= 2'(`SGC_FILTER_CYCLES);

    // reject short pulses
    // A change must persist for the full run before it is passed on
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        held[i] <= 1'b0;
        run <= 2'd0;
      end
      else if (!filter_en || raw[i] == held[i])
      begin
        held[i] <= raw[i];
        run <= 2'd0;
      end
      else if (next_run_hit)
      begin
        held[i] <= raw[i];
        run <= 2'd0;
      end
      else
      begin
        run <= run + 2'd1;
      end
    end

    chk_filter_glitch: assert property (@(posedge clock) disable iff (rst)
      (filter_en && $past(filter_en) && raw[i] != held[i] && $past(raw[i]) == held[i])
      |=> held[i] == $past(held[i]))
      else $error("glitch passed through filter");
  end

endmodule // sgc_sync_filter

// ---- sgc_source_ctl.sv ----
// Purpose: timing source fallback and input failsafe forcing
// Assumes: clk_present is a level already qualified by the clock monitor
// Notes: the forced level follows the failsafe bit while inputs are lost
`timescale 1ns/1ps
`include "sgc_params.svh"

module sgc_source_ctl (
  input wire logic clock,
  input wire logic rst,
  input wire logic auto_en,
  input wire logic clk_present,
  input wire logic failsafe_low,
  input wire logic input_lost,
  output logic use_int_osc,
  output logic failsafe_force,
  output logic failsafe_level
);

  ////////////////////////////////////////////////////////////////////////////
  // oscillator switch-over
  // Held off entirely when auto switching is cleared, even with no clock
  always_ff @(posedge clock)
  begin
    if (rst)
      use_int_osc <= 1'b0;
    else
      use_int_osc <= auto_en && !clk_present;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      failsafe_force <= 1'b0;
      failsafe_level <= 1'b0;
    end
    else
    begin
      failsafe_force <= input_lost;
      failsafe_level <= !failsafe_low;
    end
  end

  chk_osc_switch: assert property (@(posedge clock) disable iff (rst)
    (auto_en && !clk_present) |=> use_int_osc)
    else $error("no switch to internal oscillator");
  chk_osc_hold: assert property (@(posedge clock) disable iff (rst)
    !auto_en |=> !use_int_osc)
    else $error("switch-over while disabled");
  chk_failsafe_lvl: assert property (@(posedge clock) disable iff (rst)
    ##1 failsafe_level == !$past(failsafe_low))
    else $error("failsafe level wrong");

endmodule // sgc_source_ctl

// ---- sgc_config.sv ----
// Purpose: general configuration and mode select registers with their effects
// Assumes: serial control bus slave presents a one-cycle register request
// Notes: per-port fields are banked; second_port_select picks the copy written and read
`timescale 1ns/1ps
`include "sgc_params.svh"

module sgc_config (
  input wire logic clock,
  input wire logic rst,
  input wire sgc_pkg::sgc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic second_port_select,
  input wire sgc_pkg::sgc_i2c_req_t i2c_req,
  input wire sgc_pkg::sgc_remote_ans_t remote_ans,
  output logic i2c_forward,
  output logic i2c_ack_now,
  output logic i2c_nack_to_master,
  input wire logic crc_err,
  output logic crc_check_en,
  output logic [7:0] crc_err_count,
  input wire sgc_pkg::sgc_sync_t sync_in,
  output sgc_pkg::sgc_sync_t sync_out,
  input wire logic blanking,
  output logic video_valid,
  input wire logic clk_present,
  input wire logic input_lost,
  output logic use_int_osc,
  output logic failsafe_force,
  output logic failsafe_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic crc_en;
  logic filter_en;
  logic clk_auto;
  logic [1:0] auto_ack;
  logic [1:0] pass_thru;
  logic failsafe_low;
  logic crc_clr;
  logic video_gate;

  // Reset images; a literal cannot be bit-selected, so single defaults come from these
  localparam logic [7:0] gen_rst_val = `SGC_GEN_RESET;
  localparam logic [7:0] mode_rst_val = `SGC_MODE_RESET;

  // Address decode
  logic hit_gen;
  logic hit_mode;
  logic wr_gen;
  logic wr_mode;
  logic sel;
  assign sel = second_port_select;
  assign hit_gen = (reg_req.addr == `SGC_ADDR_GEN);
  assign hit_mode = (reg_req.addr == `SGC_ADDR_MODE);
  assign wr_gen = reg_req.wr && hit_gen;
  assign wr_mode = reg_req.wr && hit_mode;

  // Read views; reserved bits always show their reset values
  logic [7:0] view_gen;
  logic [7:0] view_mode;
  logic [7:0] next_rdata;
  assign view_gen = (`SGC_GEN_RESET & `SGC_GEN_RSVD_MASK)
    | {crc_en, 1'b0, auto_ack[sel], filter_en, pass_thru[sel], 1'b0, clk_auto, 1'b0};
  assign view_mode = (`SGC_MODE_RESET & `SGC_MODE_RSVD_MASK)
    | {failsafe_low, 1'b0, crc_clr, video_gate, 4'h0};
  assign next_rdata = hit_gen ? view_gen : hit_mode ? view_mode : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // general configuration shared fields
  // reserved bits have no storage, so writes to them vanish
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      crc_en <= gen_rst_val[`SGC_GEN_CRC_EN];
      filter_en <= gen_rst_val[`SGC_GEN_FILTER_EN];
      clk_auto <= gen_rst_val[`SGC_GEN_CLK_AUTO];
    end
    else if (wr_gen)
    begin
      crc_en <= reg_req.wdata[`SGC_GEN_CRC_EN];
      filter_en <= reg_req.wdata[`SGC_GEN_FILTER_EN];
      clk_auto <= reg_req.wdata[`SGC_GEN_CLK_AUTO];
    end
  end

  // banked per-port fields
  // Only the selected port's copy is written; the other keeps its setting
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    always_ff @(posedge clock)
    begin
      if (rst)
      begin
        auto_ack[p] <= gen_rst_val[`SGC_GEN_AUTO_ACK];
        pass_thru[p] <= gen_rst_val[`SGC_GEN_PASS_THRU];
      end
      else if (wr_gen && sel == 1'(p))
      begin
        auto_ack[p] <= reg_req.wdata[`SGC_GEN_AUTO_ACK];
        pass_thru[p] <= reg_req.wdata[`SGC_GEN_PASS_THRU];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      failsafe_low <= mode_rst_val[`SGC_MODE_FAILSAFE];
      crc_clr <= mode_rst_val[`SGC_MODE_CRC_CLR];
      video_gate <= mode_rst_val[`SGC_MODE_VIDEO_GATE];
    end
    else if (wr_mode)
    begin
      failsafe_low <= reg_req.wdata[`SGC_MODE_FAILSAFE];
      crc_clr <= reg_req.wdata[`SGC_MODE_CRC_CLR];
      video_gate <= reg_req.wdata[`SGC_MODE_VIDEO_GATE];
    end
  end

  // Read answer one cycle after the request; unmapped offsets read zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rdata <= reg_req.rd ? next_rdata : reg_rdata;
      reg_rvalid <= reg_req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C decisions for the requesting port
  logic req_pt;
  logic req_aa;
  logic ans_aa;
  logic next_forward;
  logic next_ack_now;
  logic next_nack;
  assign req_pt = pass_thru[i2c_req.port];
  assign req_aa = auto_ack[i2c_req.port];
  assign ans_aa = auto_ack[remote_ans.port];
  // alias match forwards only with pass-through on
  assign next_forward = i2c_req.valid
    && (i2c_req.des_hit || (i2c_req.alias_hit && req_pt));
  assign next_ack_now = next_forward && i2c_req.is_write && req_aa
    && (i2c_req.des_hit || i2c_req.pass_all);
  // remote not-acknowledge suppressed under auto acknowledge
  assign next_nack = remote_ans.valid && remote_ans.nack && !ans_aa;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      i2c_forward <= 1'b0;
      i2c_ack_now <= 1'b0;
      i2c_nack_to_master <= 1'b0;
    end
    else
    begin
      i2c_forward <= next_forward;
      i2c_ack_now <= next_ack_now;
      i2c_nack_to_master <= next_nack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC error counter
  // Held at zero while the clear bit stands; saturates rather than wrap
  logic [7:0] next_count;
  assign next_count = (crc_en && crc_err && crc_err_count != 8'hff)
    ? crc_err_count + 8'h01 : crc_err_count;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      crc_err_count <= 8'h00;
      crc_check_en <= 1'b1;
    end
    else
    begin
      crc_err_count <= crc_clr ? 8'h00 : next_count;
      crc_check_en <= crc_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sync filter and source control
  sgc_sync_filter u_filter (
    .clock(clock),
    .rst(rst),
    .filter_en(filter_en),
    .sync_in(sync_in),
    .sync_out(sync_out)
  );

  sgc_source_ctl u_source (
    .clock(clock),
    .rst(rst),
    .auto_en(clk_auto),
    .clk_present(clk_present),
    .failsafe_low(failsafe_low),
    .input_lost(input_lost),
    .use_int_osc(use_int_osc),
    .failsafe_force(failsafe_force),
    .failsafe_level(failsafe_level)
  );

  always_ff @(posedge clock)
  begin
    if (rst)
      video_valid <= 1'b0;
    else
      video_valid <= sync_out.de && !(video_gate && blanking);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_gen_write(logic [7:0] d);
    reg_req.wr && reg_req.addr == `SGC_ADDR_GEN && reg_req.wdata == d;
  endsequence
  sequence s_read_gen;
    reg_req.rd && reg_req.addr == `SGC_ADDR_GEN;
  endsequence

  chk_crc_enable: assert property (@(posedge clock) disable iff (rst)
    (wr_gen && !reg_req.wdata[7]) |=> ##1 !crc_check_en)
    else $error("crc checker not disabled");
  chk_gen_write: assert property (@(posedge clock) disable iff (rst)
    wr_gen |=> {crc_en, filter_en, clk_auto} == {$past(reg_req.wdata[`SGC_GEN_CRC_EN]),
      $past(reg_req.wdata[`SGC_GEN_FILTER_EN]), $past(reg_req.wdata[`SGC_GEN_CLK_AUTO])})
    else $error("general configuration write lost");
  chk_reserved_read: assert property (@(posedge clock) disable iff (rst)
    (s_read_gen ##0 !wr_gen) |=> reg_rvalid && reg_rdata[6] && !reg_rdata[2] && !reg_rdata[0])
    else $error("reserved bits read wrong");
  chk_mode_reserved: assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && hit_mode) |=> reg_rvalid && !reg_rdata[6] && reg_rdata[3:0] == 4'h0)
    else $error("reserved mode bits read wrong");
  chk_unmapped_read: assert property (@(posedge clock) disable iff (rst)
    (reg_req.rd && !hit_gen && !hit_mode) |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  chk_mode_write: assert property (@(posedge clock) disable iff (rst)
    wr_mode |=> {failsafe_low, crc_clr, video_gate}
      == {$past(reg_req.wdata[`SGC_MODE_FAILSAFE]), $past(reg_req.wdata[`SGC_MODE_CRC_CLR]),
      $past(reg_req.wdata[`SGC_MODE_VIDEO_GATE])})
    else $error("mode select write lost");
  chk_port_bank: assert property (@(posedge clock) disable iff (rst)
    (s_gen_write(8'hba) ##0 !sel)
    |=> auto_ack[0] && pass_thru[0] && auto_ack[1] == $past(auto_ack[1]))
    else $error("port bank not selected");
  chk_bank_keep: assert property (@(posedge clock) disable iff (rst)
    (wr_gen && sel) |=> auto_ack[0] == $past(auto_ack[0]) && pass_thru[0] == $past(pass_thru[0]))
    else $error("port 0 bank changed by port 1 write");
  chk_early_ack: assert property (@(posedge clock) disable iff (rst)
    (i2c_req.valid && i2c_req.is_write && i2c_req.des_hit && req_aa) |=> i2c_ack_now)
    else $error("write not acknowledged early");
  chk_nack_block: assert property (@(posedge clock) disable iff (rst)
    (remote_ans.valid && ans_aa) |=> !i2c_nack_to_master)
    else $error("nack leaked under auto acknowledge");
  chk_nack_pass: assert property (@(posedge clock) disable iff (rst)
    (remote_ans.valid && remote_ans.nack && !ans_aa) |=> i2c_nack_to_master)
    else $error("remote nack lost");
  chk_alias_fwd: assert property (@(posedge clock) disable iff (rst)
    (i2c_req.valid && !i2c_req.des_hit && i2c_req.alias_hit) |=> i2c_forward == $past(req_pt))
    else $error("alias forward wrong");
  chk_alias_refuse: assert property (@(posedge clock) disable iff (rst)
    (i2c_req.valid && !i2c_req.des_hit && !req_pt) |=> !i2c_forward)
    else $error("forward without pass-through");
  chk_crc_clear: assert property (@(posedge clock) disable iff (rst)
    crc_clr [*2] |-> crc_err_count == 8'h00)
    else $error("crc counter not held clear");
  chk_count_step: assert property (@(posedge clock) disable iff (rst)
    (crc_en && crc_err && !crc_clr && crc_err_count != 8'hff)
    |=> crc_err_count == $past(crc_err_count) + 8'h01)
    else $error("crc error not counted");
  chk_count_off: assert property (@(posedge clock) disable iff (rst)
    (!crc_en && !crc_clr) |=> crc_err_count == $past(crc_err_count))
    else $error("crc counted while checker off");
  chk_video_gate: assert property (@(posedge clock) disable iff (rst)
    (video_gate && blanking) |=> !video_valid)
    else $error("video during blanking");
  chk_video_pass: assert property (@(posedge clock) disable iff (rst)
    (sync_out.de && !blanking) |=> video_valid)
    else $error("active video dropped");

endmodule // sgc_config

// ---- sgc_host_model.sv ----
// Purpose: host controller model on the register port
// Assumes: one request per call, requests move 1 ns after the edge
// Notes: each task first lets an edge pass so a strobe never re-rises in one step
`timescale 1ns/1ps

module sgc_host_model (
  input wire logic clock,
  output sgc_pkg::sgc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle request from time zero
  initial reg_req = '0;

  // One-cycle write strobe
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    #1;
    reg_req = '0;
  endtask

  // Read strobe, then a bounded wait; no answer returns unknown data
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    int n;
    @(posedge clock);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clock);
    #1;
    reg_req = '0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask
endmodule // sgc_host_model

// ---- tb_top.sv ----
// Purpose: self-checking bench for the configuration registers
// Assumes: clock doubles as pixel clock; outputs are registered
// Notes: every scenario puts the registers back to reset values
`timescale 1ns/1ps

module tb_top;
  logic clock;
  logic rst;
  sgc_pkg::sgc_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic second_port_select;
  sgc_pkg::sgc_i2c_req_t i2c_req;
  sgc_pkg::sgc_remote_ans_t remote_ans;
  logic i2c_forward;
  logic i2c_ack_now;
  logic i2c_nack_to_master;
  logic crc_err;
  logic crc_check_en;
  logic [7:0] crc_err_count;
  sgc_pkg::sgc_sync_t sync_in;
  sgc_pkg::sgc_sync_t sync_out;
  logic blanking;
  logic video_valid;
  logic clk_present;
  logic input_lost;
  logic use_int_osc;
  logic failsafe_force;
  logic failsafe_level;
  int miscompares;
  int check_count;

  ////////////////////////////////////////////////////////////////////////////
  // Design and host
  sgc_config i_dut (
    .clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .second_port_select(second_port_select),
    .i2c_req(i2c_req), .remote_ans(remote_ans), .i2c_forward(i2c_forward),
    .i2c_ack_now(i2c_ack_now), .i2c_nack_to_master(i2c_nack_to_master),
    .crc_err(crc_err), .crc_check_en(crc_check_en), .crc_err_count(crc_err_count),
    .sync_in(sync_in), .sync_out(sync_out), .blanking(blanking),
    .video_valid(video_valid), .clk_present(clk_present), .input_lost(input_lost),
    .use_int_osc(use_int_osc), .failsafe_force(failsafe_force),
    .failsafe_level(failsafe_level)
  );

  sgc_host_model i_host (
    .clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_host.read_reg(addr, d);
    chk8(d, exp);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reserved and unmapped
  task automatic t_regs;
    rchk(8'h03, 8'hd2);
    rchk(8'h04, 8'h80);
    chk1(crc_check_en, 1'b1);
    i_host.write_reg(8'h03, 8'hff);
    rchk(8'h03, 8'hfa);
    i_host.write_reg(8'h03, 8'h00);
    rchk(8'h03, 8'h40);
    i_host.write_reg(8'h04, 8'hff);
    rchk(8'h04, 8'hb0);
    i_host.write_reg(8'h04, 8'h80);
    i_host.write_reg(8'h03, 8'hd2);
    i_host.write_reg(8'h10, 8'hff);
    rchk(8'h10, 8'h00);
  endtask

  // Error line high for n cycles, one count each, then a settle cycle
  task automatic crc_pulses(input int n);
    crc_err = 1'b1;
    tick(n);
    crc_err = 1'b0;
    tick(1);
  endtask

  task automatic t_crc;
    crc_pulses(3);
    chk8(crc_err_count, 8'h03);
    i_host.write_reg(8'h04, 8'ha0);
    crc_pulses(2);
    chk8(crc_err_count, 8'h00);
    i_host.write_reg(8'h04, 8'h80);
    crc_pulses(1);
    chk8(crc_err_count, 8'h01);
    i_host.write_reg(8'h03, 8'h52);
    tick(1);
    chk1(crc_check_en, 1'b0);
    crc_pulses(1);
    chk8(crc_err_count, 8'h01);
    i_host.write_reg(8'h03, 8'hd2);
  endtask

  // Request bits: port, is_write, des_hit, alias_hit, pass_all
  task automatic i2c_case(input logic [4:0] r, input logic fwd, input logic ack);
    i2c_req = {1'b1, r};
    tick(1);
    i2c_req = '0;
    chk1(i2c_forward, fwd);
    chk1(i2c_ack_now, ack);
    tick(1);
  endtask

  // Remote answer with not-acknowledge on one port
  task automatic nack_case(input logic port, input logic exp);
    remote_ans = '{valid: 1'b1, port: port, nack: 1'b1};
    tick(1);
    remote_ans = '0;
    chk1(i2c_nack_to_master, exp);
    tick(1);
  endtask

  task automatic t_i2c;
    i_host.write_reg(8'h03, 8'hba);
    rchk(8'h03, 8'hfa);
    second_port_select = 1'b1;
    rchk(8'h03, 8'hd2);
    i2c_case(5'b01100, 1'b1, 1'b1);
    i2c_case(5'b11100, 1'b1, 1'b0);
    i2c_case(5'b00010, 1'b1, 1'b0);
    i2c_case(5'b11010, 1'b0, 1'b0);
    i2c_case(5'b01011, 1'b1, 1'b1);
    nack_case(1'b0, 1'b0);
    nack_case(1'b1, 1'b1);
    i_host.write_reg(8'h03, 8'hd2);
    second_port_select = 1'b0;
    rchk(8'h03, 8'hfa);
    i_host.write_reg(8'h03, 8'hd2);
  endtask

  // Pulse one sync line for len cycles; seen if it ever comes out
  task automatic pulse(input int k, input int len, output logic seen);
    logic [2:0] so;
    seen = 1'b0;
    sync_in = sgc_pkg::sgc_sync_t'(3'b001 << k);
    tick(len);
    sync_in = '0;
    repeat (4)
    begin
      so = sync_out;
      seen = seen | so[k];
      tick(1);
    end
  endtask

  task automatic t_filter;
    logic s;
    for (int k = 0; k < 3; k++)
    begin
      pulse(k, 1, s);
      chk1(s, 1'b0);
      pulse(k, 2, s);
      chk1(s, 1'b1);
    end
    // Filter off lets the short pulse through, proving the bit matters
    i_host.write_reg(8'h03, 8'hc2);
    pulse(0, 1, s);
    chk1(s, 1'b1);
    i_host.write_reg(8'h03, 8'hd2);
  endtask

  task automatic t_video;
    sync_in = 3'b100;
    blanking = 1'b1;
    tick(4);
    chk1(video_valid, 1'b1);
    i_host.write_reg(8'h04, 8'h90);
    tick(2);
    chk1(video_valid, 1'b0);
    blanking = 1'b0;
    tick(3);
    chk1(video_valid, 1'b1);
    sync_in = '0;
    i_host.write_reg(8'h04, 8'h80);
  endtask

  task automatic t_source;
    clk_present = 1'b0;
    tick(2);
    chk1(use_int_osc, 1'b1);
    i_host.write_reg(8'h03, 8'hd0);
    tick(1);
    chk1(use_int_osc, 1'b0);
    clk_present = 1'b1;
    i_host.write_reg(8'h03, 8'hd2);
    input_lost = 1'b1;
    tick(2);
    chk1(failsafe_force, 1'b1);
    chk1(failsafe_level, 1'b0);
    i_host.write_reg(8'h04, 8'h00);
    tick(1);
    chk1(failsafe_level, 1'b1);
    input_lost = 1'b0;
    i_host.write_reg(8'h04, 8'h80);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Main sequence
  initial
  begin
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    second_port_select = 1'b0;
    i2c_req = '0;
    remote_ans = '0;
    crc_err = 1'b0;
    sync_in = '0;
    blanking = 1'b0;
    clk_present = 1'b1;
    input_lost = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    t_regs;
    t_crc;
    t_i2c;
    t_filter;
    t_video;
    t_source;
    give_verdict;
  end

  // Watchdog: the run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    give_verdict;
  end
endmodule // tb_top
